// ===== hw/brmw_pkg.sv
// brmw_pkg: constants and carrier types for the bridge memory window and secondary status
package brmw_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_COMMAND = 8'h04;
  localparam logic [7:0] IDX_SEC_STATUS = 8'h1E;
  localparam logic [7:0] IDX_MEM_BASE = 8'h20;
  localparam logic [7:0] IDX_MEM_LIMIT = 8'h22;
  localparam logic [7:0] IDX_BRIDGE_CTRL = 8'h3E;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam int BUS_ADDR_W = 10;

  // secondary status fields
  localparam int TST_LSB = 9;
  localparam logic [1:0] TST_MEDIUM = 2'h1;
  localparam int MPF_BIT = 8;
  localparam int FB2B_BIT = 7;
  localparam int HSC_BIT = 5;

  // window fields
  localparam int WIN_MSB = 15;
  localparam int WIN_LSB = 4;
  localparam int ADDR_WIN_MSB = 31;
  localparam int ADDR_WIN_LSB = 20;
  localparam logic [11:0] RST_WIN = 12'h000;

  // control fields
  localparam int PERR_EN_BIT = 0;
  localparam int CMD_MSE_BIT = 1;
  localparam int CMD_BME_BIT = 2;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_PARITY_BIT = 0;
  localparam int IRQ_BLOCKED_BIT = 1;
  localparam logic [1:0] RST_IRQ = 2'h0;

  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } brmw_req_type;

  typedef struct packed {
    logic valid;
    logic forward;
  } brmw_dec_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } brmw_bus_state_type;

endpackage : brmw_pkg

// ===== hw/brmw_top.sv
// brmw_top: memory window decode, secondary status and register slave of the bridge
`timescale 1ns/10ps
module brmw_top #(
  parameter int BUS_ADDR_W = brmw_pkg::BUS_ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [BUS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rd_perr_driven,
  input wire logic i_wr_perr_seen,
  input wire logic i_pcix_mode,
  input wire logic i_split_data_uncorr,
  input wire logic i_split_wr_err_msg,
  input wire brmw_pkg::brmw_req_type i_dn_req,
  input wire brmw_pkg::brmw_req_type i_up_req,
  output brmw_pkg::brmw_dec_type o_dn_dec,
  output brmw_pkg::brmw_dec_type o_up_dec,
  output logic o_irq
);

  if (BUS_ADDR_W < 10) begin : g_addr_chk
    $error("brmw_top: bus address too narrow for the register map");
  end

  brmw_pkg::brmw_bus_state_type bus_state_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [11:0] base_ff;
  logic [11:0] limit_ff;
  logic mpf_ff;
  logic [15:0] bctrl_ff;
  logic [15:0] cmd_ff;
  logic [brmw_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [brmw_pkg::IRQ_W-1:0] irq_mask_ff;
  brmw_pkg::brmw_dec_type dn_dec_ff;
  brmw_pkg::brmw_dec_type up_dec_ff;
  logic irq_ff;

  logic acc_req;
  logic acc_wr;
  logic acc_rd;
  logic [31:0] nxt_rdata;
  logic [15:0] sec_status;
  logic perr_en;
  logic mse;
  logic bme;
  logic mpf_set;
  logic mpf_clr;
  logic dn_hit;
  logic up_hit;
  logic blocked;
  logic [brmw_pkg::IRQ_W-1:0] irq_events;
  logic [15:0] base_merged;
  logic [15:0] limit_merged;

  // word-aligned decode of one register index
  function automatic logic reg_hit(input logic [BUS_ADDR_W-1:0] addr, input logic [7:0] idx);
    logic [BUS_ADDR_W-1:0] byte_addr;
    byte_addr = BUS_ADDR_W'({idx, 2'b00});
    reg_hit = (addr == byte_addr);
  endfunction : reg_hit

  // byte-lane merge for a 16-bit register held in the low lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    merge16 = res;
  endfunction : merge16

  // window match on address bits 31:20
  function automatic logic in_window(input logic [31:0] addr, input logic [11:0] base,
                                     input logic [11:0] limit);
    logic [11:0] a;
    a = addr[brmw_pkg::ADDR_WIN_MSB:brmw_pkg::ADDR_WIN_LSB];
    in_window = (limit > base)
             && (a >= base)
             && (a < limit);
  endfunction : in_window

  assign acc_req = i_avs_read || i_avs_write;
  // bus state ack is the one cycle with waitrequest low; the master still holds its request
  assign acc_wr = (bus_state_ff == brmw_pkg::BUS_ACK) && i_avs_write;
  assign acc_rd = (bus_state_ff == brmw_pkg::BUS_ACK) && i_avs_read;

  assign perr_en = bctrl_ff[brmw_pkg::PERR_EN_BIT];
  assign mse = cmd_ff[brmw_pkg::CMD_MSE_BIT];
  assign bme = cmd_ff[brmw_pkg::CMD_BME_BIT];
  assign base_merged = merge16({base_ff, 4'h0}, i_avs_writedata, i_avs_byteenable);
  assign limit_merged = merge16({limit_ff, 4'h0}, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    sec_status = 16'h0000;
    sec_status[brmw_pkg::TST_LSB +: 2] = brmw_pkg::TST_MEDIUM;
    sec_status[brmw_pkg::MPF_BIT] = mpf_ff;
    sec_status[brmw_pkg::FB2B_BIT] = 1'b1;
    sec_status[brmw_pkg::HSC_BIT] = 1'b1;
  end

  always_comb begin
    nxt_rdata = brmw_pkg::RST_RDATA;
    if (reg_hit(i_avs_address, brmw_pkg::IDX_SEC_STATUS)) begin
      nxt_rdata[15:0] = sec_status;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_MEM_BASE)) begin
      nxt_rdata[brmw_pkg::WIN_MSB:brmw_pkg::WIN_LSB] = base_ff;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_MEM_LIMIT)) begin
      nxt_rdata[brmw_pkg::WIN_MSB:brmw_pkg::WIN_LSB] = limit_ff;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_BRIDGE_CTRL)) begin
      nxt_rdata[15:0] = bctrl_ff;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_COMMAND)) begin
      nxt_rdata[15:0] = cmd_ff;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_IRQ_STATUS)) begin
      nxt_rdata[brmw_pkg::IRQ_W-1:0] = irq_stat_ff;
    end else if (reg_hit(i_avs_address, brmw_pkg::IDX_IRQ_MASK)) begin
      nxt_rdata[brmw_pkg::IRQ_W-1:0] = irq_mask_ff;
    end
  end

  // fixed one-cycle answer; readdata is captured as waitrequest falls
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bus_state_ff <= brmw_pkg::BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= brmw_pkg::RST_RDATA;
    end else begin
      unique case (bus_state_ff)
        brmw_pkg::BUS_IDLE: begin
          if (acc_req) begin
            bus_state_ff <= brmw_pkg::BUS_ACK;
            wait_ff <= 1'b0;
            rdata_ff <= i_avs_read ? nxt_rdata : brmw_pkg::RST_RDATA;
          end
        end
        brmw_pkg::BUS_ACK: begin
          bus_state_ff <= brmw_pkg::BUS_IDLE;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      base_ff <= brmw_pkg::RST_WIN;
      limit_ff <= brmw_pkg::RST_WIN;
    end else if (acc_wr) begin
      // low nibble is dropped on write, so the window stays 1 MB aligned
      if (reg_hit(i_avs_address, brmw_pkg::IDX_MEM_BASE)) begin
        base_ff <= base_merged[brmw_pkg::WIN_MSB:brmw_pkg::WIN_LSB];
      end
      if (reg_hit(i_avs_address, brmw_pkg::IDX_MEM_LIMIT)) begin
        limit_ff <= limit_merged[brmw_pkg::WIN_MSB:brmw_pkg::WIN_LSB];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bctrl_ff <= brmw_pkg::RST_CTRL;
      cmd_ff <= brmw_pkg::RST_CTRL;
    end else if (acc_wr) begin
      if (reg_hit(i_avs_address, brmw_pkg::IDX_BRIDGE_CTRL)) begin
        bctrl_ff <= merge16(bctrl_ff, i_avs_writedata, i_avs_byteenable);
      end
      if (reg_hit(i_avs_address, brmw_pkg::IDX_COMMAND)) begin
        cmd_ff <= merge16(cmd_ff, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // master parity fault flag
  always_comb begin
    mpf_set = perr_en && (
              i_rd_perr_driven
           || i_wr_perr_seen
           || (i_pcix_mode && i_split_data_uncorr)
           || (i_pcix_mode && i_split_wr_err_msg));
    mpf_clr = acc_wr && reg_hit(i_avs_address, brmw_pkg::IDX_SEC_STATUS)
           && i_avs_byteenable[1] && i_avs_writedata[brmw_pkg::MPF_BIT];
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mpf_ff <= 1'b0;
    end else if (mpf_set) begin
      // a new fault beats a same-cycle clear
      mpf_ff <= 1'b1;
    end else if (mpf_clr) begin
      mpf_ff <= 1'b0;
    end
  end

  // window decode for both directions
  assign dn_hit = in_window(i_dn_req.addr, base_ff, limit_ff);
  assign up_hit = in_window(i_up_req.addr, base_ff, limit_ff);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dn_dec_ff <= '0;
      up_dec_ff <= '0;
    end else begin
      dn_dec_ff.valid <= i_dn_req.valid;
      dn_dec_ff.forward <= i_dn_req.valid && dn_hit && mse;
      up_dec_ff.valid <= i_up_req.valid;
      up_dec_ff.forward <= i_up_req.valid && !up_hit && bme;
    end
  end

  // interrupt status: sticky, cleared by reading it; new events win over the clear
  assign blocked = (i_dn_req.valid && dn_hit && !mse) || (i_up_req.valid && !up_hit && !bme);

  always_comb begin
    irq_events = '0;
    irq_events[brmw_pkg::IRQ_PARITY_BIT] = mpf_set;
    irq_events[brmw_pkg::IRQ_BLOCKED_BIT] = blocked;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_stat_ff <= brmw_pkg::RST_IRQ;
    end else if (acc_rd && reg_hit(i_avs_address, brmw_pkg::IDX_IRQ_STATUS)) begin
      irq_stat_ff <= irq_events;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_events;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_mask_ff <= brmw_pkg::RST_IRQ;
    end else if (acc_wr && reg_hit(i_avs_address, brmw_pkg::IDX_IRQ_MASK)) begin
      if (i_avs_byteenable[0]) begin
        irq_mask_ff <= i_avs_writedata[brmw_pkg::IRQ_W-1:0];
      end
    end
  end

  // registered, so the line trails the status bit by one cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign o_dn_dec = dn_dec_ff;
  assign o_up_dec = up_dec_ff;
  assign o_irq = irq_ff;

  // checks
  default clocking cb_main @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  logic rd_status_done;
  logic rd_base_done;
  logic rd_limit_done;
  assign rd_status_done = acc_rd && reg_hit(i_avs_address, brmw_pkg::IDX_SEC_STATUS);
  assign rd_base_done = acc_rd && reg_hit(i_avs_address, brmw_pkg::IDX_MEM_BASE);
  assign rd_limit_done = acc_rd && reg_hit(i_avs_address, brmw_pkg::IDX_MEM_LIMIT);

  property p_tst_fixed;
    rd_status_done |-> (o_avs_readdata[10:9] == 2'b01);
  endproperty
  a_tst_fixed: assert property (p_tst_fixed) else $error("decode timing field wrong");

  property p_caps_fixed;
    rd_status_done |-> (o_avs_readdata[7] && o_avs_readdata[5] && !o_avs_readdata[6]);
  endproperty
  a_caps_fixed: assert property (p_caps_fixed) else $error("capability bits wrong");

  property p_hsc_fixed;
    rd_status_done |-> o_avs_readdata[5];
  endproperty
  a_hsc_fixed: assert property (p_hsc_fixed) else $error("high speed bit not one");

  property p_rd_perr_sets;
    (perr_en && i_rd_perr_driven) |=> mpf_ff;
  endproperty
  a_rd_perr_sets: assert property (p_rd_perr_sets) else $error("read parity fault lost");

  property p_wr_perr_sets;
    (perr_en && i_wr_perr_seen) |=> mpf_ff;
  endproperty
  a_wr_perr_sets: assert property (p_wr_perr_sets) else $error("write parity fault lost");

  property p_split_sets;
    (perr_en && i_pcix_mode && (i_split_data_uncorr || i_split_wr_err_msg)) |=> mpf_ff;
  endproperty
  a_split_sets: assert property (p_split_sets) else $error("split error not flagged");

  property p_split_conv;
    (!i_pcix_mode && !i_rd_perr_driven && !i_wr_perr_seen && !mpf_ff) |=> !mpf_ff;
  endproperty
  a_split_conv: assert property (p_split_conv) else $error("flag set outside PCI-X");

  property p_sticky;
    (mpf_ff && !mpf_clr) |=> mpf_ff [*1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("parity flag dropped");

  property p_gate;
    (!perr_en && !mpf_ff) |=> !mpf_ff;
  endproperty
  a_gate: assert property (p_gate) else $error("flag set while response disabled");

  property p_low_nibble;
    (rd_base_done || rd_limit_done) |-> (o_avs_readdata[3:0] == 4'h0);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("window low bits not zero");

  property p_below_base;
    (i_dn_req.valid && i_dn_req.addr[31:20] < base_ff) |=> !o_dn_dec.forward;
  endproperty
  a_below_base: assert property (p_below_base) else $error("forward below base");

  property p_at_limit;
    (i_dn_req.valid && i_dn_req.addr[31:20] >= limit_ff) |=> !o_dn_dec.forward;
  endproperty
  a_at_limit: assert property (p_at_limit) else $error("forward at or above limit");

  property p_dn_fwd;
    (i_dn_req.valid && dn_hit && mse) |=> (o_dn_dec.valid && o_dn_dec.forward);
  endproperty
  a_dn_fwd: assert property (p_dn_fwd) else $error("inbound hit not forwarded");

  property p_up_fwd;
    i_up_req.valid |=> (o_up_dec.forward == ($past(!up_hit) && $past(bme)));
  endproperty
  a_up_fwd: assert property (p_up_fwd) else $error("upstream decision wrong");

  property p_empty;
    (i_dn_req.valid && limit_ff <= base_ff) |=> !o_dn_dec.forward;
  endproperty
  a_empty: assert property (p_empty) else $error("empty window matched");

  property p_base_wr;
    (acc_wr && reg_hit(i_avs_address, brmw_pkg::IDX_MEM_BASE) && (&i_avs_byteenable[1:0]))
      |=> (base_ff == $past(i_avs_writedata[15:4]));
  endproperty
  a_base_wr: assert property (p_base_wr) else $error("base write not stored");

  property p_ctrl_bit0;
    (acc_wr && reg_hit(i_avs_address, brmw_pkg::IDX_BRIDGE_CTRL) && i_avs_byteenable[0])
      |=> (perr_en == $past(i_avs_writedata[0]));
  endproperty
  a_ctrl_bit0: assert property (p_ctrl_bit0) else $error("response enable not bit0");

  c_fault_irq: cover property (mpf_set ##[1:3] o_irq);
  c_dn_forward: cover property (i_dn_req.valid && dn_hit && mse ##1 o_dn_dec.forward);
  c_up_forward: cover property (i_up_req.valid ##1 o_up_dec.forward);
  c_clear_flag: cover property (mpf_ff ##1 mpf_clr ##1 !mpf_ff);

endmodule : brmw_top

// ===== verif/brmw_far_model.sv
// brmw_far_model: pcie port and pci agents issuing accesses and error events
`timescale 1ns/10ps
module brmw_far_model (
  input wire logic i_clock,
  output brmw_pkg::brmw_req_type o_dn_req,
  output brmw_pkg::brmw_req_type o_up_req,
  output logic [3:0] o_event,
  output logic o_pcix
);
  initial begin
    o_dn_req = '0;
    o_up_req = '0;
    o_event = 4'h0;
    o_pcix = 1'b0;
  end

  // one access each way in the same cycle, valid as a single pulse
  task automatic send(input logic [31:0] dn, input logic [31:0] up);
    @(posedge i_clock);
    o_dn_req <= '{valid: 1'b1, addr: dn};
    o_up_req <= '{valid: 1'b1, addr: up};
    @(posedge i_clock);
    o_dn_req <= '{valid: 1'b0, addr: ~dn};
    o_up_req <= '{valid: 1'b0, addr: ~up};
  endtask : send

  // k: 0 read perr driven, 1 write perr seen, 2 split data, 3 split write msg
  task automatic pulse(input int k);
    pulse_px(k, k >= 2);
  endtask : pulse

  // event k with the pci-x mode level given
  task automatic pulse_px(input int k, input logic px);
    @(posedge i_clock);
    o_pcix <= px;
    o_event[k] <= 1'b1;
    @(posedge i_clock);
    o_event[k] <= 1'b0;
  endtask : pulse_px
endmodule : brmw_far_model

// ===== verif/testbench.sv
// testbench: register, decode, parity flag and interrupt checks of brmw_top
`timescale 1ns/10ps
module testbench;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [9:0] av_addr = 10'h000;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0000_0000;
  logic [3:0] av_be = 4'hF;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [3:0] ev;
  logic pcix;
  logic irq;
  brmw_pkg::brmw_req_type dn_req;
  brmw_pkg::brmw_req_type up_req;
  brmw_pkg::brmw_dec_type dn_dec;
  brmw_pkg::brmw_dec_type up_dec;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [31:0] SST_IDLE = 32'h0000_02A0;
  localparam logic [31:0] SST_FLAG = 32'h0000_03A0;

  always #2.5 i_clock = ~i_clock;

  brmw_far_model far (.i_clock(i_clock), .o_dn_req(dn_req), .o_up_req(up_req),
    .o_event(ev), .o_pcix(pcix));

  brmw_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
    .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .i_rd_perr_driven(ev[0]), .i_wr_perr_seen(ev[1]), .i_pcix_mode(pcix),
    .i_split_data_uncorr(ev[2]), .i_split_wr_err_msg(ev[3]), .i_dn_req(dn_req),
    .i_up_req(up_req), .o_dn_dec(dn_dec), .o_up_dec(up_dec), .o_irq(irq));

  task automatic results;
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge i_clock);
    av_addr <= {idx, 2'b00};
    av_wr <= wr;
    av_rd <= ~wr;
    av_wd <= wd;
    // ends when waitrequest is sampled low; if it never falls, only the run's hang guard ends this wait
    do begin
      @(posedge i_clock);
    end while (av_wait !== 1'b0);
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0000_0000, x);
    chk_reg(x, exp);
  endtask : rd_chk

  task automatic dec(input logic [31:0] dn, input logic [31:0] up,
                     input logic e_dn, input logic e_up);
    far.send(dn, up);
    #1;
    chk_bit(dn_dec.valid, 1'b1);
    chk_bit(dn_dec.forward, e_dn);
    chk_bit(up_dec.valid, 1'b1);
    chk_bit(up_dec.forward, e_up);
  endtask : dec

  task automatic t_reset;
    rd_chk(brmw_pkg::IDX_MEM_BASE, 32'h0000_0000);
    rd_chk(brmw_pkg::IDX_MEM_LIMIT, 32'h0000_0000);
    rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    wr(brmw_pkg::IDX_SEC_STATUS, 32'h0000_FEFF);
    rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    wr(8'h30, 32'h0000_FFFF);
    rd_chk(8'h30, 32'h0000_0000);
  endtask : t_reset

  task automatic t_window;
    logic [31:0] a [4];
    logic h [4];
    a = '{32'h1230_0000, 32'h122F_FFFF, 32'h125F_FFFF, 32'h1260_0000};
    h = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(brmw_pkg::IDX_MEM_BASE, 32'h0000_FFFF);
    rd_chk(brmw_pkg::IDX_MEM_BASE, 32'h0000_FFF0);
    wr(brmw_pkg::IDX_MEM_BASE, 32'h0000_123F);
    wr(brmw_pkg::IDX_MEM_LIMIT, 32'h0000_126F);
    rd_chk(brmw_pkg::IDX_MEM_LIMIT, 32'h0000_1260);
    wr(brmw_pkg::IDX_COMMAND, 32'h0000_0006);
    for (int i = 0; i < 4; i++) begin
      dec(a[i], a[i], h[i], ~h[i]);
    end
    wr(brmw_pkg::IDX_COMMAND, 32'h0000_0002);
    dec(32'h1240_0000, 32'h0010_0000, 1'b1, 1'b0);
    wr(brmw_pkg::IDX_COMMAND, 32'h0000_0004);
    dec(32'h1240_0000, 32'h0010_0000, 1'b0, 1'b1);
    rd_chk(brmw_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
    rd_chk(brmw_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
    wr(brmw_pkg::IDX_COMMAND, 32'h0000_0006);
    wr(brmw_pkg::IDX_MEM_LIMIT, 32'h0000_1230);
    dec(32'h1230_0000, 32'h1230_0000, 1'b0, 1'b1);
    wr(brmw_pkg::IDX_MEM_LIMIT, 32'h0000_1000);
    dec(32'h1100_0000, 32'h1300_0000, 1'b0, 1'b1);
  endtask : t_window

  task automatic t_parity;
    for (int k = 0; k < 4; k++) begin
      far.pulse(k);
      rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    end
    wr(brmw_pkg::IDX_BRIDGE_CTRL, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      far.pulse(k);
      rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_FLAG);
      wr(brmw_pkg::IDX_SEC_STATUS, 32'h0000_0000);
      rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_FLAG);
      wr(brmw_pkg::IDX_SEC_STATUS, 32'h0000_0100);
      rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    end
    far.pulse_px(2, 1'b0);
    rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    far.pulse_px(3, 1'b0);
    rd_chk(brmw_pkg::IDX_SEC_STATUS, SST_IDLE);
    // status holds the parity event but the mask keeps the line low
    chk_bit(irq, 1'b0);
    rd_chk(brmw_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
  endtask : t_parity

  task automatic t_irq;
    far.pulse(1);
    repeat (3) @(posedge i_clock);
    chk_bit(irq, 1'b0);
    wr(brmw_pkg::IDX_IRQ_MASK, 32'h0000_0001);
    rd_chk(brmw_pkg::IDX_IRQ_MASK, 32'h0000_0001);
    chk_bit(irq, 1'b1);
    rd_chk(brmw_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge i_clock);
    chk_bit(irq, 1'b0);
  endtask : t_irq

  initial begin
    repeat (20) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_window();
    t_parity();
    t_irq();
    results();
  end
endmodule : testbench
